// >>> core/chgp_pkg.sv
package chgp_pkg;
  // timing base and figures
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned CLK_KHZ       = CLK_HZ / 1000;
  localparam int unsigned T_BOOST_MS    = 30;
  localparam int unsigned T_BIAS_TYP_MS = 220;
  localparam int unsigned T_BIAS_MIN_MS = 100;
  localparam int unsigned T_CONTACT_MS  = 40;
  localparam int unsigned T_DCD_TMO_MS  = 500;
  localparam int unsigned T_RETRY_S     = 2;
  localparam int unsigned BOOST_DLY_CYC = T_BOOST_MS * CLK_KHZ;
  localparam int unsigned BIAS_DLY_CYC  = T_BIAS_TYP_MS * CLK_KHZ;
  localparam int unsigned CONTACT_CYC   = T_CONTACT_MS * CLK_KHZ;
  localparam int unsigned DCD_TMO_CYC   = T_DCD_TMO_MS * CLK_KHZ;
  localparam int unsigned RETRY_CYC     = T_RETRY_S * CLK_HZ;
  localparam int unsigned TMR_W         = 26;
  typedef logic [TMR_W-1:0] chgp_tmr_t;

  // register byte offsets
  localparam logic [7:0] ADDR_INLIM  = 8'h00;
  localparam logic [7:0] ADDR_CHGCFG = 8'h04;
  localparam logic [7:0] ADDR_TIMER  = 8'h08;
  localparam logic [7:0] ADDR_BOOST  = 8'h0c;
  localparam logic [7:0] ADDR_MISC   = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_FAULT  = 8'h18;

  // field positions
  localparam int unsigned FLD_HIZ     = 7;
  localparam int unsigned FLD_LIM     = 0;
  localparam int unsigned FLD_REGRST  = 7;
  localparam int unsigned FLD_CHGCFG  = 4;
  localparam int unsigned FLD_WDOG    = 4;
  localparam int unsigned FLD_BOOST_LEVEL_SELECT  = 4;
  localparam int unsigned FLD_FORCE   = 7;
  localparam int unsigned FLD_SW_OFF  = 5;
  localparam int unsigned FLD_SRC     = 6;
  localparam int unsigned FLD_PG      = 2;
  localparam int unsigned FLD_BFAULT  = 6;

  // values after reset
  localparam logic [2:0] LIM_RST       = 3'h2;
  localparam logic [1:0] CHGCFG_RST    = 2'h1;
  localparam logic [1:0] WDOG_RST      = 2'h1;
  localparam logic [3:0] BOOST_LEVEL_SELECT_RST    = 4'h7;

  // encodings
  localparam logic [2:0] ILIM_100MA    = 3'h0;
  localparam logic [2:0] ILIM_500MA    = 3'h2;
  localparam logic [2:0] ILIM_1A       = 3'h4;
  localparam logic [2:0] ILIM_2A       = 3'h6;
  localparam logic [2:0] ILIM_3A       = 3'h7;
  localparam logic [1:0] SRC_NONE      = 2'h0;
  localparam logic [1:0] SRC_HOST      = 2'h1;
  localparam logic [1:0] SRC_ADAPTER   = 2'h2;
  localparam logic [1:0] SRC_BOOST     = 2'h3;
  localparam logic [1:0] CHGCFG_BOOST  = 2'h2;
  localparam logic [1:0] NSTD_DIV1     = 2'h1;
  localparam logic [1:0] NSTD_DIV2     = 2'h2;
  localparam logic [1:0] NSTD_DIV3     = 2'h3;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {Q_IDLE, Q_CHECK, Q_RETRY, Q_GOOD} chgp_qual_e;
  typedef enum logic [2:0] {D_IDLE, D_DCD_ON, D_DCD_WAIT, D_PRI, D_NSTD} chgp_det_e;

  typedef struct packed {
    logic       bat_above_depl;
    logic       bat_above_low;
    logic       vin_above_uvlo;
    logic       vin_above_sleep;
    logic       vin_overvolt;
    logic       poor_src_ok;
    logic       sys_overload;
    logic       boost_fault;
    logic       dp_low;
    logic       dm_high;
    logic [1:0] nstd_class;
  } chgp_sense_t;

  typedef struct packed {
    logic dp_isrc;
    logic dm_pulldn;
    logic dp_vsrc;
    logic dm_isink;
  } chgp_dpdm_t;
endpackage

// >>> core/chgp_top.sv
// Contract
// - battery only and above depletion: close battery switch, bias regulator off.
// - system overload opens battery switch until input source attaches again.
// - host setting battery switch off bit opens the battery switch.
// - attach, write zero, watchdog, register reset, wake edge close switch, clear bit.
// - boost starts on battery ok, input low, pin high, config 10, 30ms.
// - source type reads 11 while boost is active.
// - boost level defaults to 5.1V and follows the four-bit select field.
// - boost fault sets fault bit 6 and asserts the interrupt.
// - input above battery plus margin closes blocking switch, charge mode on.
// - bias regulator on after undervoltage, sleep condition and 220ms delay.
// - any bias condition false keeps high impedance idle, regulator off.
// - qualified input sets power good bit, drives pin low, interrupts.
// - failed poor source check retries every 2 seconds.
// - after power good, detection runs on attach unless host holds idle.
// - detection reports source type, loads limit; host may overwrite limit.
// - contact detect first, then primary or non-standard detection.
// - primary detection drives 40ms; D- low is host, high charging port.
// - host port 500mA status 01, charging port 3A status 10.
// - non-standard per divider class status 10; none gives 00 and 500mA.
// - force bit runs detection at 100mA, clears itself, applies new limit.
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module chgp_top #(
  parameter chgp_pkg::chgp_tmr_t BOOST_DLY_CYC = chgp_pkg::chgp_tmr_t'(chgp_pkg::BOOST_DLY_CYC),
  parameter chgp_pkg::chgp_tmr_t BIAS_DLY_CYC  = chgp_pkg::chgp_tmr_t'(chgp_pkg::BIAS_DLY_CYC),
  parameter chgp_pkg::chgp_tmr_t CONTACT_CYC   = chgp_pkg::chgp_tmr_t'(chgp_pkg::CONTACT_CYC),
  parameter chgp_pkg::chgp_tmr_t DCD_TMO_CYC   = chgp_pkg::chgp_tmr_t'(chgp_pkg::DCD_TMO_CYC),
  parameter chgp_pkg::chgp_tmr_t RETRY_CYC     = chgp_pkg::chgp_tmr_t'(chgp_pkg::RETRY_CYC)
) (
  input  wire logic                  CORE_CLK,        // core clock
  input  wire logic                  SYS_RST,         // async reset, high
  input  wire chgp_pkg::chgp_sense_t SENSE,           // comparator levels
  input  wire logic                  BOOST_PIN,       // boost enable pin
  input  wire logic                  SHIP_WAKE_PIN,   // wake from shipping
  input  wire logic                  WDOG_EXPIRED,    // watchdog expiry pulse
  output logic                       BATTERY_SWITCH,  // battery switch closed
  output logic                       BIAS_REG_EN,     // internal bias regulator on
  output logic                       HIGH_IMP_IDLE,   // idle, regulator off
  output logic                       INPUT_BLOCKING_SWITCH, // input switch closed
  output logic                       CHARGE_MODE,     // charge mode on
  output logic                       BOOST_EN,        // boost running
  output logic [3:0]                 BOOST_LEVEL_SELECT, // boost level code
  output logic                       POWER_GOOD_N_PIN, // low when good
  output logic                       INT_PULSE,       // interrupt event
  output logic [2:0]                 ILIM_ACTIVE,     // limit in force
  output chgp_pkg::chgp_dpdm_t       DPDM_DRV,        // D+/D- drivers
  input  wire logic [7:0]            S_AXI_AWADDR,    // write address
  input  wire logic                  S_AXI_AWVALID,   // write address valid
  output logic                       S_AXI_AWREADY,   // write address ready
  input  wire logic [31:0]           S_AXI_WDATA,     // write data
  input  wire logic [3:0]            S_AXI_WSTRB,     // byte enables
  input  wire logic                  S_AXI_WVALID,    // write data valid
  output logic                       S_AXI_WREADY,    // write data ready
  output logic [1:0]                 S_AXI_BRESP,     // write response
  output logic                       S_AXI_BVALID,    // write response valid
  input  wire logic                  S_AXI_BREADY,    // write response ready
  input  wire logic [7:0]            S_AXI_ARADDR,    // read address
  input  wire logic                  S_AXI_ARVALID,   // read address valid
  output logic                       S_AXI_ARREADY,   // read address ready
  output logic [31:0]                S_AXI_RDATA,     // read data
  output logic [1:0]                 S_AXI_RRESP,     // read response
  output logic                       S_AXI_RVALID,    // read data valid
  input  wire logic                  S_AXI_RREADY     // read data ready
);

  typedef struct packed {
    logic                 aw_ok;
    logic [7:0]           aw_addr;
    logic                 w_ok;
    logic [7:0]           w_data;
    logic                 w_strb0;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [7:0]           rdata;
    logic [1:0]           rresp;
    logic                 high_impedance_idle;
    logic [2:0]           lim;
    logic [1:0]           chgcfg;
    logic [1:0]           wdog;
    logic [3:0]           boost_level_select;
    logic                 force_det;
    logic                 sw_off;
    logic                 sw_trip;
    logic                 sw_on;
    logic                 vin_d;
    logic                 wake_d;
    logic [1:0]           src;
    logic                 pg;
    logic                 bfault;
    logic                 irq;
    logic                 boost_on;
    chgp_pkg::chgp_tmr_t  boost_cnt;
    logic                 bias_on;
    chgp_pkg::chgp_tmr_t  bias_cnt;
    chgp_pkg::chgp_qual_e qst;
    chgp_pkg::chgp_tmr_t  qual_cnt;
    chgp_pkg::chgp_det_e  dst;
    chgp_pkg::chgp_tmr_t  det_cnt;
    logic                 det_pend;
  } chgp_state_t;

  chgp_state_t s_r;
  chgp_state_t s_nxt;

  logic       wr_go;
  logic       rd_go;
  logic       attach;
  logic       wake_rise;
  logic       boost_req;
  logic       bias_cond;
  logic [7:0] wd;
  logic [7:0] rmux;
  logic       rhit;

  assign S_AXI_AWREADY         = !s_r.aw_ok && !s_r.bvalid;
  assign S_AXI_WREADY          = !s_r.w_ok && !s_r.bvalid;
  assign S_AXI_ARREADY         = !s_r.rvalid;
  assign S_AXI_BVALID          = s_r.bvalid;
  assign S_AXI_BRESP           = s_r.bresp;
  assign S_AXI_RVALID          = s_r.rvalid;
  assign S_AXI_RRESP           = s_r.rresp;
  assign S_AXI_RDATA           = {24'h000000, s_r.rdata};
  assign BATTERY_SWITCH        = s_r.sw_on;
  assign BIAS_REG_EN           = s_r.bias_on;
  assign HIGH_IMP_IDLE         = !s_r.bias_on;
  assign INPUT_BLOCKING_SWITCH = s_r.vin_d && SENSE.vin_above_sleep;
  assign CHARGE_MODE           = s_r.vin_d && SENSE.vin_above_sleep;
  assign BOOST_EN              = s_r.boost_on;
  assign BOOST_LEVEL_SELECT    = s_r.boost_level_select;
  assign POWER_GOOD_N_PIN      = !s_r.pg;
  assign INT_PULSE             = s_r.irq;
  // limit held at 100mA while detection runs
  assign ILIM_ACTIVE = (s_r.dst != chgp_pkg::D_IDLE) ? chgp_pkg::ILIM_100MA : s_r.lim;
  assign DPDM_DRV.dp_isrc   = (s_r.dst == chgp_pkg::D_DCD_ON) || (s_r.dst == chgp_pkg::D_DCD_WAIT);
  assign DPDM_DRV.dm_pulldn = (s_r.dst == chgp_pkg::D_DCD_ON) || (s_r.dst == chgp_pkg::D_DCD_WAIT);
  assign DPDM_DRV.dp_vsrc   = (s_r.dst == chgp_pkg::D_PRI);
  assign DPDM_DRV.dm_isink  = (s_r.dst == chgp_pkg::D_PRI);

  always_comb begin
    rhit = 1'b1;
    rmux = 8'h00;
    unique case (S_AXI_ARADDR)
      chgp_pkg::ADDR_INLIM:  rmux = {s_r.high_impedance_idle, 4'h0, s_r.lim};
      chgp_pkg::ADDR_CHGCFG: rmux = {2'h0, s_r.chgcfg, 4'h0};
      chgp_pkg::ADDR_TIMER:  rmux = {2'h0, s_r.wdog, 4'h0};
      chgp_pkg::ADDR_BOOST:  rmux = {s_r.boost_level_select, 4'h0};
      chgp_pkg::ADDR_MISC:   rmux = {s_r.force_det, 1'b0, s_r.sw_off, 5'h00};
      chgp_pkg::ADDR_STATUS: rmux = {(s_r.boost_on ? chgp_pkg::SRC_BOOST : s_r.src),
                                     3'h0, s_r.pg, 2'h0};
      chgp_pkg::ADDR_FAULT:  rmux = {1'b0, s_r.bfault, 6'h00};
      default:               rhit = 1'b0;
    endcase
  end

  always_comb begin
    s_nxt     = s_r;
    wd        = s_r.w_data;
    wr_go     = s_r.aw_ok && s_r.w_ok && !s_r.bvalid;
    rd_go     = S_AXI_ARVALID && !s_r.rvalid;
    attach    = SENSE.vin_above_uvlo && !s_r.vin_d;
    wake_rise = SHIP_WAKE_PIN && !s_r.wake_d;
    s_nxt.vin_d  = SENSE.vin_above_uvlo;
    s_nxt.wake_d = SHIP_WAKE_PIN;
    s_nxt.irq    = 1'b0;

    // bus channels
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      s_nxt.aw_ok   = 1'b1;
      s_nxt.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      s_nxt.w_ok    = 1'b1;
      s_nxt.w_data  = S_AXI_WDATA[7:0];
      s_nxt.w_strb0 = S_AXI_WSTRB[0];
    end
    if (s_r.bvalid && S_AXI_BREADY) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.rvalid && S_AXI_RREADY) begin
      s_nxt.rvalid = 1'b0;
    end
    if (rd_go) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rmux;
      s_nxt.rresp  = rhit ? chgp_pkg::RESP_OKAY : chgp_pkg::RESP_SLVERR;
      if (S_AXI_ARADDR == chgp_pkg::ADDR_FAULT) begin
        s_nxt.bfault = 1'b0;
      end
    end

    // shipping mode wake events close the switch again
    if (attach || WDOG_EXPIRED || wake_rise) begin
      s_nxt.sw_off = 1'b0;
    end
    // re-attach of the input releases an overload trip
    if (attach) begin
      s_nxt.sw_trip = 1'b0;
    end

    if (wr_go) begin
      s_nxt.aw_ok  = 1'b0;
      s_nxt.w_ok   = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = chgp_pkg::RESP_OKAY;
      unique case (s_r.aw_addr)
        chgp_pkg::ADDR_INLIM: begin
          if (s_r.w_strb0) begin
            s_nxt.high_impedance_idle = wd[chgp_pkg::FLD_HIZ];
            s_nxt.lim = wd[chgp_pkg::FLD_LIM +: 3];
          end
        end
        chgp_pkg::ADDR_CHGCFG: begin
          if (s_r.w_strb0 && wd[chgp_pkg::FLD_REGRST]) begin
            s_nxt.high_impedance_idle       = 1'b0;
            s_nxt.lim       = chgp_pkg::LIM_RST;
            s_nxt.chgcfg    = chgp_pkg::CHGCFG_RST;
            s_nxt.wdog      = chgp_pkg::WDOG_RST;
            s_nxt.boost_level_select    = chgp_pkg::BOOST_LEVEL_SELECT_RST;
            s_nxt.force_det = 1'b0;
            s_nxt.sw_off    = 1'b0;
          end else if (s_r.w_strb0) begin
            s_nxt.chgcfg = wd[chgp_pkg::FLD_CHGCFG +: 2];
          end
        end
        chgp_pkg::ADDR_TIMER: begin
          if (s_r.w_strb0) begin
            s_nxt.wdog = wd[chgp_pkg::FLD_WDOG +: 2];
          end
        end
        chgp_pkg::ADDR_BOOST: begin
          if (s_r.w_strb0) begin
            s_nxt.boost_level_select = wd[chgp_pkg::FLD_BOOST_LEVEL_SELECT +: 4];
          end
        end
        chgp_pkg::ADDR_MISC: begin
          if (s_r.w_strb0) begin
            s_nxt.force_det = wd[chgp_pkg::FLD_FORCE];
            s_nxt.sw_off    = wd[chgp_pkg::FLD_SW_OFF];
          end
        end
        default: begin
          s_nxt.bresp = chgp_pkg::RESP_SLVERR;
        end
      endcase
    end

    // battery switch
    if (SENSE.sys_overload) begin
      s_nxt.sw_trip = 1'b1;
    end
    s_nxt.sw_on = SENSE.bat_above_depl && !s_nxt.sw_off && !s_nxt.sw_trip;

    // boost start conditions and delay
    boost_req = SENSE.bat_above_low && !SENSE.vin_above_sleep && BOOST_PIN
                && (s_r.chgcfg == chgp_pkg::CHGCFG_BOOST);
    if (!boost_req) begin
      s_nxt.boost_cnt = '0;
      s_nxt.boost_on  = 1'b0;
    end else if (s_r.boost_cnt == BOOST_DLY_CYC - 1'b1) begin
      s_nxt.boost_on = 1'b1;
    end else begin
      s_nxt.boost_cnt = s_r.boost_cnt + 1'b1;
    end
    if (s_r.boost_on && SENSE.boost_fault) begin
      s_nxt.bfault = 1'b1;
      if (!s_r.bfault) begin
        s_nxt.irq = 1'b1;
      end
    end

    // bias regulator enable
    bias_cond = SENSE.vin_above_uvlo && !s_r.high_impedance_idle
                && (s_r.boost_on ? !SENSE.vin_above_sleep : SENSE.vin_above_sleep);
    if (!bias_cond) begin
      s_nxt.bias_cnt = '0;
      s_nxt.bias_on  = 1'b0;
    end else if (s_r.bias_cnt == BIAS_DLY_CYC - 1'b1) begin
      s_nxt.bias_on = 1'b1;
    end else begin
      s_nxt.bias_cnt = s_r.bias_cnt + 1'b1;
    end

    // input source qualification
    unique case (s_r.qst)
      chgp_pkg::Q_IDLE: begin
        if (s_r.bias_on) begin
          s_nxt.qst = chgp_pkg::Q_CHECK;
        end
      end
      chgp_pkg::Q_CHECK: begin
        if (!SENSE.vin_overvolt && SENSE.poor_src_ok) begin
          s_nxt.qst      = chgp_pkg::Q_GOOD;
          s_nxt.pg       = 1'b1;
          s_nxt.irq      = 1'b1;
          s_nxt.det_pend = 1'b1;
        end else if (!SENSE.vin_overvolt) begin
          s_nxt.qst      = chgp_pkg::Q_RETRY;
          s_nxt.qual_cnt = '0;
        end
      end
      chgp_pkg::Q_RETRY: begin
        if (s_r.qual_cnt == RETRY_CYC - 1'b1) begin
          s_nxt.qst = chgp_pkg::Q_CHECK;
        end else begin
          s_nxt.qual_cnt = s_r.qual_cnt + 1'b1;
        end
      end
      chgp_pkg::Q_GOOD: begin
        if (SENSE.vin_overvolt) begin
          s_nxt.qst = chgp_pkg::Q_CHECK;
          s_nxt.pg  = 1'b0;
        end
      end
    endcase
    if (!s_r.bias_on) begin
      s_nxt.qst      = chgp_pkg::Q_IDLE;
      s_nxt.pg       = 1'b0;
      s_nxt.det_pend = 1'b0;
    end

    // D+/D- source detection
    s_nxt.det_cnt = s_r.det_cnt + 1'b1;
    unique case (s_r.dst)
      chgp_pkg::D_IDLE: begin
        s_nxt.det_cnt = '0;
        if (s_r.pg && !s_r.high_impedance_idle && (s_r.det_pend || s_r.force_det)) begin
          s_nxt.dst      = chgp_pkg::D_DCD_ON;
          s_nxt.det_pend = 1'b0;
          s_nxt.src      = chgp_pkg::SRC_NONE;
        end
      end
      chgp_pkg::D_DCD_ON: begin
        if (s_r.det_cnt == CONTACT_CYC - 1'b1) begin
          s_nxt.dst     = chgp_pkg::D_DCD_WAIT;
          s_nxt.det_cnt = '0;
        end
      end
      chgp_pkg::D_DCD_WAIT: begin
        s_nxt.det_cnt = '0;
        if (SENSE.dp_low) begin
          s_nxt.dst = chgp_pkg::D_PRI;
        end else if (s_r.det_cnt == DCD_TMO_CYC - 1'b1) begin
          s_nxt.dst = chgp_pkg::D_NSTD;
        end else begin
          s_nxt.det_cnt = s_r.det_cnt + 1'b1;
        end
      end
      chgp_pkg::D_PRI: begin
        if (s_r.det_cnt == CONTACT_CYC - 1'b1) begin
          s_nxt.dst       = chgp_pkg::D_IDLE;
          s_nxt.force_det = 1'b0;
          if (SENSE.dm_high) begin
            s_nxt.src = chgp_pkg::SRC_ADAPTER;
            s_nxt.lim = chgp_pkg::ILIM_3A;
          end else begin
            s_nxt.src = chgp_pkg::SRC_HOST;
            s_nxt.lim = chgp_pkg::ILIM_500MA;
          end
        end
      end
      chgp_pkg::D_NSTD: begin
        s_nxt.dst       = chgp_pkg::D_IDLE;
        s_nxt.force_det = 1'b0;
        s_nxt.src       = chgp_pkg::SRC_ADAPTER;
        unique case (SENSE.nstd_class)
          chgp_pkg::NSTD_DIV1: s_nxt.lim = chgp_pkg::ILIM_2A;
          chgp_pkg::NSTD_DIV2: s_nxt.lim = chgp_pkg::ILIM_2A;
          chgp_pkg::NSTD_DIV3: s_nxt.lim = chgp_pkg::ILIM_1A;
          default: begin
            s_nxt.src = chgp_pkg::SRC_NONE;
            s_nxt.lim = chgp_pkg::ILIM_500MA;
          end
        endcase
      end
      default: begin
        s_nxt.dst = chgp_pkg::D_IDLE;
      end
    endcase
    if (!s_r.pg) begin
      s_nxt.dst = chgp_pkg::D_IDLE;
      s_nxt.src = chgp_pkg::SRC_NONE;
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s_r        <= '0;
      s_r.lim    <= chgp_pkg::LIM_RST;
      s_r.chgcfg <= chgp_pkg::CHGCFG_RST;
      s_r.wdog   <= chgp_pkg::WDOG_RST;
      s_r.boost_level_select <= chgp_pkg::BOOST_LEVEL_SELECT_RST;
      s_r.qst    <= chgp_pkg::Q_IDLE;
      s_r.dst    <= chgp_pkg::D_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule // chgp_top
`default_nettype wire

// >>> tb/chgp_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module chgp_asserts (
  input wire logic                  CORE_CLK,              // clock
  input wire logic                  SYS_RST,               // reset
  input wire chgp_pkg::chgp_sense_t SENSE,                 // levels
  input wire logic                  BOOST_PIN,             // pin
  input wire logic                  BATTERY_SWITCH,        // switch
  input wire logic                  BIAS_REG_EN,           // bias
  input wire logic                  HIGH_IMP_IDLE,         // idle
  input wire logic                  INPUT_BLOCKING_SWITCH, // input
  input wire logic                  CHARGE_MODE,           // charge
  input wire logic                  BOOST_EN,              // boost
  input wire logic                  POWER_GOOD_N_PIN,      // good
  input wire logic                  INT_PULSE,             // event
  input wire logic [2:0]            ILIM_ACTIVE,           // limit
  input wire chgp_pkg::chgp_dpdm_t  DPDM_DRV               // drivers
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  property p_idle; HIGH_IMP_IDLE == !BIAS_REG_EN; endproperty
  a_idle: assert property (p_idle) else $error("idle vs bias");
  property p_trip; SENSE.sys_overload |=> !BATTERY_SWITCH; endproperty
  a_trip: assert property (p_trip) else $error("switch kept on");
  property p_blk; INPUT_BLOCKING_SWITCH == CHARGE_MODE
    && INPUT_BLOCKING_SWITCH == (SENSE.vin_above_sleep && $past(SENSE.vin_above_uvlo));
  endproperty
  a_blk: assert property (p_blk) else $error("input switch");
  property p_bst; $rose(BOOST_EN) |-> $past(BOOST_PIN, 8) && $past(!SENSE.vin_above_sleep); endproperty
  a_bst: assert property (p_bst) else $error("boost start");
  property p_bias; $rose(BIAS_REG_EN) |-> $past(SENSE.vin_above_uvlo, 8); endproperty
  a_bias: assert property (p_bias) else $error("bias start");
  property p_pg; $fell(POWER_GOOD_N_PIN) |-> INT_PULSE && BIAS_REG_EN; endproperty
  a_pg: assert property (p_pg) else $error("good event");
  property p_lim; (|DPDM_DRV) |-> ILIM_ACTIVE == 3'h0; endproperty
  a_lim: assert property (p_lim) else $error("limit in detect");
  property p_drv; DPDM_DRV.dp_isrc == DPDM_DRV.dm_pulldn && DPDM_DRV.dp_vsrc == DPDM_DRV.dm_isink;
  endproperty
  a_drv: assert property (p_drv) else $error("driver pairs");
endmodule // chgp_asserts
bind chgp_top chgp_asserts u_chk (.*);
`default_nettype wire

// >>> tb/chgp_port_model.sv
`timescale 1ns/1ns
`default_nettype none
module chgp_port_model (
  input  wire chgp_pkg::chgp_dpdm_t drv,     // device drivers
  input  wire logic [1:0]           kind,    // 0 open, 1 host, 2 charger
  output logic                      dp_low,  // d+ pulled low
  output logic                      dm_high  // d- raised
);
  assign dp_low  = drv.dp_isrc & (kind != 2'h0);
  assign dm_high = drv.dp_vsrc & (kind == 2'h2);
endmodule // chgp_port_model
`default_nettype wire

// >>> tb/charger_powerup_source_detect_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module charger_powerup_source_detect_tb_top;
  typedef struct packed {logic [7:0] a; logic [31:0] d, e; logic [1:0] r;} chgp_row_t;
  typedef struct packed {logic [1:0] k, n; logic [2:0] l; logic [31:0] s;} chgp_drow_t;
  logic CORE_CLK = 1'h0, SYS_RST = 1'h1, BOOST_PIN = 1'h0, SHIP_WAKE_PIN = 1'h0;
  logic WDOG_EXPIRED = 1'h0, S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
  logic S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_ARREADY, S_AXI_RVALID, BATTERY_SWITCH, BIAS_REG_EN, HIGH_IMP_IDLE, BOOST_EN;
  logic INPUT_BLOCKING_SWITCH, CHARGE_MODE, POWER_GOOD_N_PIN, INT_PULSE, dp_low, dm_high;
  logic [7:0]  S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rd;
  logic [3:0]  S_AXI_WSTRB = 4'hf, BOOST_LEVEL_SELECT;
  logic [2:0]  ILIM_ACTIVE;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rp, kind = 2'h2;
  chgp_pkg::chgp_sense_t sn = '0, SENSE;
  chgp_pkg::chgp_dpdm_t  DPDM_DRV;
  int fail_count = 0, n_checks = 0;
  chgp_row_t  rows [4] = '{'{8'h00, 32'h83, 32'h83, 2'h0}, '{8'h08, 32'h0, 32'h0, 2'h0},
                           '{8'h0c, 32'h50, 32'h50, 2'h0}, '{8'h1c, 32'hff, 32'h0, 2'h2}};
  chgp_drow_t drs [6] = '{'{2'h2, 2'h0, 3'h7, 32'h84}, '{2'h1, 2'h0, 3'h2, 32'h44},
                          '{2'h0, 2'h0, 3'h2, 32'h04}, '{2'h0, 2'h1, 3'h6, 32'h84},
                          '{2'h0, 2'h2, 3'h6, 32'h84}, '{2'h0, 2'h3, 3'h4, 32'h84}};
  always #20 CORE_CLK = ~CORE_CLK;
  always_comb begin
    SENSE = sn;
    SENSE.dp_low = dp_low;
    SENSE.dm_high = dm_high;
  end
  chgp_top #(.BOOST_DLY_CYC(26'd20), .BIAS_DLY_CYC(26'd30), .CONTACT_CYC(26'd10),
             .DCD_TMO_CYC(26'd40), .RETRY_CYC(26'd25)) uut (.*);
  chgp_port_model u_port (.drv(DPDM_DRV), .kind(kind), .dp_low(dp_low), .dm_high(dm_high));
  task automatic ck(input logic [35:0] g, input logic [35:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one register access; w selects write, the reply lands in rd and rp
  task automatic ax(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, pb;
    pa = 1'h1; pw = w; pb = 1'h1;
    @(posedge CORE_CLK);
    S_AXI_AWADDR <= a; S_AXI_ARADDR <= a; S_AXI_WDATA <= d;
    S_AXI_AWVALID <= w; S_AXI_WVALID <= w; S_AXI_BREADY <= w;
    S_AXI_ARVALID <= !w; S_AXI_RREADY <= !w;
    while (pb) begin
      @(negedge CORE_CLK);
      pa = pa & !(w ? S_AXI_AWREADY : S_AXI_ARREADY);
      pw = pw & !S_AXI_WREADY;
      pb = !(w ? S_AXI_BVALID : S_AXI_RVALID);
      rd = S_AXI_RDATA;
      rp = w ? S_AXI_BRESP : S_AXI_RRESP;
      @(posedge CORE_CLK);
      S_AXI_AWVALID <= pa & w; S_AXI_WVALID <= pw; S_AXI_BREADY <= pb & w;
      S_AXI_ARVALID <= pa & !w; S_AXI_RREADY <= pb & !w;
    end
  endtask
  initial begin
    #400000;
    fail_count++;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    ck({ILIM_ACTIVE, POWER_GOOD_N_PIN}, {chgp_pkg::LIM_RST, 1'h1});
    @(posedge CORE_CLK);
    SYS_RST <= 1'h0; sn.bat_above_depl <= 1'h1; sn.bat_above_low <= 1'h1;
    repeat (3) @(negedge CORE_CLK);
    ck({BATTERY_SWITCH, BIAS_REG_EN}, 2'b10);
    ax(1'h0, chgp_pkg::ADDR_BOOST, 32'h0); ck(rd, 32'h70);
    foreach (rows[i]) begin
      ax(1'h1, rows[i].a, rows[i].d); ck(rp, rows[i].r);
      ax(1'h0, rows[i].a, 32'h0);
      ck({rd, rp}, {rows[i].e, rows[i].r});
    end
    $display("registers done");
    ax(1'h1, chgp_pkg::ADDR_MISC, 32'h20);
    repeat (2) @(negedge CORE_CLK);
    ck({BATTERY_SWITCH, BOOST_LEVEL_SELECT}, {1'h0, 4'h5});
    @(posedge CORE_CLK);
    SHIP_WAKE_PIN <= 1'h1;
    repeat (3) @(negedge CORE_CLK);
    ck(BATTERY_SWITCH, 1'h1);
    ax(1'h0, chgp_pkg::ADDR_MISC, 32'h0); ck(rd, 32'h0);
    ax(1'h1, chgp_pkg::ADDR_MISC, 32'h20);
    WDOG_EXPIRED <= 1'h1;
    @(posedge CORE_CLK);
    WDOG_EXPIRED <= 1'h0;
    @(negedge CORE_CLK);
    ck(BATTERY_SWITCH, 1'h1);
    ax(1'h1, chgp_pkg::ADDR_MISC, 32'h20);
    ax(1'h1, chgp_pkg::ADDR_CHGCFG, 32'h80);
    @(negedge CORE_CLK);
    ck({BATTERY_SWITCH, BOOST_LEVEL_SELECT}, {1'h1, chgp_pkg::BOOST_LEVEL_SELECT_RST});
    @(posedge CORE_CLK);
    sn.vin_above_uvlo <= 1'h1; sn.vin_above_sleep <= 1'h1;
    repeat (2) @(negedge CORE_CLK);
    ck({INPUT_BLOCKING_SWITCH, CHARGE_MODE}, 2'b11);
    repeat (40) @(negedge CORE_CLK);
    ck({POWER_GOOD_N_PIN, HIGH_IMP_IDLE}, 2'b10);
    @(posedge CORE_CLK);
    sn.poor_src_ok <= 1'h1;
    repeat (200) if (POWER_GOOD_N_PIN) @(negedge CORE_CLK);
    ck({POWER_GOOD_N_PIN, HIGH_IMP_IDLE}, 2'b00);
    repeat (120) @(negedge CORE_CLK);
    foreach (drs[i]) begin
      @(posedge CORE_CLK);
      kind <= drs[i].k; sn.nstd_class <= drs[i].n;
      ax(1'h1, chgp_pkg::ADDR_MISC, 32'h80);
      repeat (120) @(negedge CORE_CLK);
      ck(ILIM_ACTIVE, drs[i].l);
      ax(1'h0, chgp_pkg::ADDR_STATUS, 32'h0); ck(rd, drs[i].s);
    end
    ax(1'h0, chgp_pkg::ADDR_MISC, 32'h0); ck(rd, 32'h0);
    $display("detection done");
    @(posedge CORE_CLK);
    sn.sys_overload <= 1'h1;
    @(posedge CORE_CLK);
    sn.sys_overload <= 1'h0; sn.vin_above_uvlo <= 1'h0; sn.vin_above_sleep <= 1'h0;
    repeat (3) @(negedge CORE_CLK);
    ck({BATTERY_SWITCH, INPUT_BLOCKING_SWITCH}, 2'b00);
    @(posedge CORE_CLK);
    sn.vin_above_uvlo <= 1'h1;
    repeat (2) @(negedge CORE_CLK);
    ck(BATTERY_SWITCH, 1'h1);
    @(posedge CORE_CLK);
    sn.vin_above_uvlo <= 1'h0;
    ax(1'h1, chgp_pkg::ADDR_CHGCFG, 32'h20);
    BOOST_PIN <= 1'h1;
    repeat (200) if (!BOOST_EN) @(negedge CORE_CLK);
    ck(BOOST_EN, 1'h1);
    ax(1'h0, chgp_pkg::ADDR_STATUS, 32'h0); ck(rd[7:6], 2'b11);
    sn.boost_fault <= 1'h1;
    repeat (2) @(negedge CORE_CLK);
    ck(INT_PULSE, 1'h1);
    ax(1'h0, chgp_pkg::ADDR_FAULT, 32'h0); ck(rd, 32'h40);
    sn.bat_above_depl <= 1'h0;
    ax(1'h1, chgp_pkg::ADDR_MISC, 32'h20);
    @(negedge CORE_CLK);
    ck(BATTERY_SWITCH, 1'h0);
    $display("boost done");
    tally_and_finish;
  end
endmodule // charger_powerup_source_detect_tb_top
`default_nettype wire
